// *** sys_ctrl_pkg.sv ***
// constants, register map and carrier types of the system clock and
// reset control block
// assumes a word-wide register bus with setup and access phases
`default_nettype none

package sys_ctrl_pkg;

  // block base and decoded window
  localparam logic [31:0] BASE_ADDR = 32'h4004_8000;
  localparam int BLOCK_LSB = 14;

  // register offsets
  localparam logic [11:0] OFF_REMAP = 12'h000;
  localparam logic [11:0] OFF_PRESET = 12'h004;
  localparam logic [11:0] OFF_PLLSTAT = 12'h00c;
  localparam logic [11:0] OFF_RSTSTAT = 12'h030;
  localparam logic [11:0] OFF_PLLSEL = 12'h040;
  localparam logic [11:0] OFF_PLLUPD = 12'h044;
  localparam logic [11:0] OFF_MAINSEL = 12'h070;
  localparam logic [11:0] OFF_MAINUPD = 12'h074;
  localparam logic [11:0] OFF_GATE = 12'h080;
  localparam logic [11:0] OFF_PINSEL = 12'h0e0;
  localparam logic [11:0] OFF_PINUPD = 12'h0e4;
  localparam logic [11:0] OFF_CAP0 = 12'h100;
  localparam logic [11:0] OFF_CAP1 = 12'h104;
  localparam logic [11:0] OFF_PARTID = 12'h3f4;

  // dividers: system, sync serial 0, serial, sync serial 1,
  // watchdog, tick timer, clock pin
  localparam int NUM_DIV = 7;
  localparam int DIV_SYS = 0;
  localparam int DIV_PIN = 6;
  localparam logic [NUM_DIV-1:0][11:0] DIV_OFF = {
    12'h0e8, 12'h0d4, 12'h0d0, 12'h09c, 12'h098, 12'h094, 12'h078};
  localparam logic [NUM_DIV-1:0][7:0] DIV_RST = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};

  // plain configuration words: crystal, watchdog osc,
  // internal osc, low freq osc, brown-out, tick calibration,
  // nonmaskable source, pin irq select 0..7, run power config
  localparam int NUM_PLAIN = 16;
  localparam logic [NUM_PLAIN-1:0][11:0] PLAIN_OFF = {
    12'h238, 12'h194, 12'h190, 12'h18c, 12'h188, 12'h184, 12'h180,
    12'h17c, 12'h178, 12'h174, 12'h158, 12'h150, 12'h02c, 12'h028,
    12'h024, 12'h020};
  localparam logic [NUM_PLAIN-1:0][31:0] PLAIN_RST = {
    32'h0000_edf0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0000_0004, 32'h0, 32'h0000_00a0,
    32'h0000_0080, 32'h0000_00a0, 32'h0};
  // pll control word sits at offset 0x008 and is kept apart
  localparam logic [11:0] OFF_PLLCTRL = 12'h008;

  // reset values
  localparam logic [11:0] PRESET_RST = 12'h000;
  localparam logic [11:0] PRESET_MASK = 12'hff7;
  localparam logic [31:0] GATE_RST = 32'h0000_001f;
  localparam int RST_CAUSES = 5;
  // arbitrary value, identifies no real part
  localparam logic [31:0] PART_ID = 32'h0000_1234;

  // lowest bytes redirected by a remap
  localparam logic [31:0] REMAP_WINDOW = 32'h0000_0200;

  typedef enum logic [1:0] {
    MAP_BOOT_ROM, MAP_RAM, MAP_FLASH, MAP_RESERVED
  } remap_e;

  typedef enum logic [1:0] {
    PLL_FROM_INTERNAL, PLL_FROM_CRYSTAL, PLL_FROM_EXT_PIN, PLL_RESERVED
  } pll_src_e;

  typedef enum logic [1:0] {
    MAIN_FROM_INTERNAL, MAIN_FROM_PLL_INPUT, MAIN_FROM_WATCHDOG,
    MAIN_FROM_PLL_OUTPUT
  } main_src_e;

  typedef enum logic [2:0] {
    PIN_FROM_INTERNAL, PIN_FROM_CRYSTAL, PIN_FROM_WATCHDOG,
    PIN_FROM_MAIN, PIN_FROM_LOW_FREQ, PIN_RES5, PIN_RES6, PIN_RES7
  } pin_src_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    pll_src_e pll;
    main_src_e main;
    pin_src_e pin;
  } clk_sel_s;

endpackage : sys_ctrl_pkg

`default_nettype wire

// *** system_clock_reset_control.sv ***
// system clock and reset control: register block, source selection,
// gating, dividers, vector remap and peripheral soft resets
// assumes a word-wide peripheral bus slave port and one system clock;
// oscillators, pll and clock muxes sit outside and follow the outputs
//
// How it works
// - after reset the main clock runs from the internal fast oscillator
// - four oscillators: crystal, 12 MHz internal, low freq, watchdog
// - pll input chosen from crystal, internal osc or external clock pin
// - each gating bit enables system clock to one peripheral or memory
// - programmable dividers give serial, sync serial, watchdog, tick clocks
// - clock output pin undivided or divided by 2 to 255
// - every register sits on a 32-bit word boundary
// - block decoded at base 0x4004_8000, registers at listed offsets
// - remap value 0 selects boot rom, value 1 selects static ram
// - remap resets to 2, flash vectors; encoding 3 reserved
// - remap redirects only the lowest 512 bytes
// - peripheral reset bit 0 holds reset, 1 releases it
// - reset bits 0-2 serial/wire, 3 reserved, 4-11 others, rest reserved
// - every access is a full word; no partial writes
`default_nettype none

module system_clock_reset_control (
  input wire logic clk,
  input wire logic arst_n,
  input wire sys_ctrl_pkg::apb_req_s apbReq,
  output sys_ctrl_pkg::apb_rsp_s apbRsp,
  input wire logic pllLocked,
  input wire logic [sys_ctrl_pkg::RST_CAUSES-1:0] resetCauseEvent,
  input wire logic [31:0] porPins0,
  input wire logic [31:0] porPins1,
  input wire logic [31:0] fetchAddr,
  output sys_ctrl_pkg::remap_e vectorMap,
  output logic fetchToRom,
  output logic fetchToRam,
  output logic [11:0] periphResetN,
  output logic [31:0] clockGate,
  output sys_ctrl_pkg::clk_sel_s clockSel,
  output logic [sys_ctrl_pkg::NUM_DIV-1:0] dividerTick,
  output logic [31:0] pllConfig,
  output logic [sys_ctrl_pkg::NUM_PLAIN-1:0][31:0] configWords
);

  typedef struct packed {
    sys_ctrl_pkg::apb_rsp_s rsp;
    sys_ctrl_pkg::remap_e map;
    logic romHit;
    logic ramHit;
    logic [11:0] presetN;
    sys_ctrl_pkg::clk_sel_s pending;
    sys_ctrl_pkg::clk_sel_s active;
    logic pllUpd;
    logic mainUpd;
    logic pinUpd;
    logic [31:0] gate;
    logic [sys_ctrl_pkg::NUM_DIV-1:0][7:0] div;
    logic [sys_ctrl_pkg::NUM_DIV-1:0][7:0] cnt;
    logic [sys_ctrl_pkg::NUM_DIV-1:0] tick;
    logic [31:0] pllCtrl;
    logic [sys_ctrl_pkg::NUM_PLAIN-1:0][31:0] plain;
    logic [sys_ctrl_pkg::RST_CAUSES-1:0] rstStat;
    logic capDone;
    logic [31:0] cap0;
    logic [31:0] cap1;
  } state_s;

  state_s state;
  state_s next_state;

  logic setupPhase;
  logic wrStrobe;
  logic inBlock;
  logic [11:0] offset;
  logic [31:0] wdata;
  logic [31:0] rdValue;
  logic mapped;

  assign setupPhase = apbReq.psel && !apbReq.penable;
  // write lands in the access phase, whole word at once
  assign wrStrobe = apbReq.psel && apbReq.penable && apbReq.pwrite &&
                    state.rsp.pready;
  // only the first 4 kB page holds registers; the rest of the window
  // answers with an error instead of aliasing onto that page
  assign inBlock = (apbReq.paddr[31:sys_ctrl_pkg::BLOCK_LSB] ==
                    sys_ctrl_pkg::BASE_ADDR[31:sys_ctrl_pkg::BLOCK_LSB]) &&
                   (apbReq.paddr[13:12] == 2'b00);
  // low address bits ignored: registers are word aligned
  assign offset = {apbReq.paddr[11:2], 2'b00};
  assign wdata = apbReq.pwdata;

  // read decode and mapped check
  always_comb begin
    rdValue = 32'h0;
    mapped = 1'b1;
    case (offset)
      sys_ctrl_pkg::OFF_REMAP: rdValue = {30'h0, state.map};
      sys_ctrl_pkg::OFF_PRESET: rdValue = {20'h0, state.presetN};
      sys_ctrl_pkg::OFF_PLLCTRL: rdValue = state.pllCtrl;
      sys_ctrl_pkg::OFF_PLLSTAT: rdValue = {31'h0, pllLocked};
      sys_ctrl_pkg::OFF_RSTSTAT: rdValue = {27'h0, state.rstStat};
      sys_ctrl_pkg::OFF_PLLSEL: rdValue = {30'h0, state.pending.pll};
      sys_ctrl_pkg::OFF_PLLUPD: rdValue = {31'h0, state.pllUpd};
      sys_ctrl_pkg::OFF_MAINSEL: rdValue = {30'h0, state.pending.main};
      sys_ctrl_pkg::OFF_MAINUPD: rdValue = {31'h0, state.mainUpd};
      sys_ctrl_pkg::OFF_GATE: rdValue = state.gate;
      sys_ctrl_pkg::OFF_PINSEL: rdValue = {29'h0, state.pending.pin};
      sys_ctrl_pkg::OFF_PINUPD: rdValue = {31'h0, state.pinUpd};
      sys_ctrl_pkg::OFF_CAP0: rdValue = state.cap0;
      sys_ctrl_pkg::OFF_CAP1: rdValue = state.cap1;
      sys_ctrl_pkg::OFF_PARTID: rdValue = sys_ctrl_pkg::PART_ID;
      default: begin
        mapped = 1'b0;
        for (int i = 0; i < sys_ctrl_pkg::NUM_DIV; i++) begin
          if (offset == sys_ctrl_pkg::DIV_OFF[i]) begin
            rdValue = {24'h0, state.div[i]};
            mapped = 1'b1;
          end
        end
        for (int i = 0; i < sys_ctrl_pkg::NUM_PLAIN; i++) begin
          if (offset == sys_ctrl_pkg::PLAIN_OFF[i]) begin
            rdValue = state.plain[i];
            mapped = 1'b1;
          end
        end
      end
    endcase
    if (!inBlock) begin
      mapped = 1'b0;
      rdValue = 32'h0;
    end
  end

  always_comb begin
    next_state = state;

    // bus answer: data and error captured in setup, ready in access
    next_state.rsp.pready = setupPhase;
    if (setupPhase) begin
      next_state.rsp.prdata = rdValue;
      next_state.rsp.pslverr = !mapped;
    end else if (!apbReq.psel) begin
      next_state.rsp.pslverr = 1'b0;
    end

    // power-on pin levels caught once after reset release
    if (!state.capDone) begin
      next_state.capDone = 1'b1;
      next_state.cap0 = porPins0;
      next_state.cap1 = porPins1;
    end

    // register writes; unmapped offsets are ignored
    if (wrStrobe && inBlock) begin
      case (offset)
        sys_ctrl_pkg::OFF_REMAP: begin
          // reserved encoding is refused, old mapping kept
          if (wdata[1:0] != sys_ctrl_pkg::MAP_RESERVED) begin
            next_state.map = sys_ctrl_pkg::remap_e'(wdata[1:0]);
          end
        end
        sys_ctrl_pkg::OFF_PRESET:
          next_state.presetN = wdata[11:0] & sys_ctrl_pkg::PRESET_MASK;
        sys_ctrl_pkg::OFF_PLLCTRL: next_state.pllCtrl = wdata;
        sys_ctrl_pkg::OFF_RSTSTAT:
          next_state.rstStat = state.rstStat &
                               ~wdata[sys_ctrl_pkg::RST_CAUSES-1:0];
        sys_ctrl_pkg::OFF_PLLSEL: begin
          if (wdata[1:0] != sys_ctrl_pkg::PLL_RESERVED) begin
            next_state.pending.pll = sys_ctrl_pkg::pll_src_e'(wdata[1:0]);
          end
        end
        sys_ctrl_pkg::OFF_PLLUPD: begin
          next_state.pllUpd = wdata[0];
          if (wdata[0] && !state.pllUpd) begin
            next_state.active.pll = state.pending.pll;
          end
        end
        sys_ctrl_pkg::OFF_MAINSEL:
          next_state.pending.main = sys_ctrl_pkg::main_src_e'(wdata[1:0]);
        sys_ctrl_pkg::OFF_MAINUPD: begin
          next_state.mainUpd = wdata[0];
          if (wdata[0] && !state.mainUpd) begin
            next_state.active.main = state.pending.main;
          end
        end
        sys_ctrl_pkg::OFF_GATE: next_state.gate = wdata;
        sys_ctrl_pkg::OFF_PINSEL: begin
          if (wdata[2:0] <= 3'(sys_ctrl_pkg::PIN_FROM_LOW_FREQ)) begin
            next_state.pending.pin = sys_ctrl_pkg::pin_src_e'(wdata[2:0]);
          end
        end
        sys_ctrl_pkg::OFF_PINUPD: begin
          next_state.pinUpd = wdata[0];
          if (wdata[0] && !state.pinUpd) begin
            next_state.active.pin = state.pending.pin;
          end
        end
        default: begin
          for (int i = 0; i < sys_ctrl_pkg::NUM_DIV; i++) begin
            if (offset == sys_ctrl_pkg::DIV_OFF[i]) begin
              next_state.div[i] = wdata[7:0];
            end
          end
          for (int i = 0; i < sys_ctrl_pkg::NUM_PLAIN; i++) begin
            if (offset == sys_ctrl_pkg::PLAIN_OFF[i]) begin
              next_state.plain[i] = wdata;
            end
          end
        end
      endcase
    end

    // reset causes: a new event wins over a clear in the same cycle
    next_state.rstStat = next_state.rstStat | resetCauseEvent;

    // dividers: 0 stops, 1 passes every cycle, n ticks once in n
    for (int i = 0; i < sys_ctrl_pkg::NUM_DIV; i++) begin
      if (state.div[i] == 8'h00) begin
        next_state.cnt[i] = 8'h00;
        next_state.tick[i] = 1'b0;
      end else if (state.cnt[i] >= state.div[i] - 8'h01) begin
        next_state.cnt[i] = 8'h00;
        next_state.tick[i] = 1'b1;
      end else begin
        next_state.cnt[i] = state.cnt[i] + 8'h01;
        next_state.tick[i] = 1'b0;
      end
    end

    // lowest window of the address map follows the remap field
    next_state.romHit = (fetchAddr < sys_ctrl_pkg::REMAP_WINDOW) &&
                        (state.map == sys_ctrl_pkg::MAP_BOOT_ROM);
    next_state.ramHit = (fetchAddr < sys_ctrl_pkg::REMAP_WINDOW) &&
                        (state.map == sys_ctrl_pkg::MAP_RAM);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state.rsp <= '0;
      state.map <= sys_ctrl_pkg::MAP_FLASH;
      state.romHit <= 1'b0;
      state.ramHit <= 1'b0;
      state.presetN <= sys_ctrl_pkg::PRESET_RST;
      state.pending <= {sys_ctrl_pkg::PLL_FROM_INTERNAL,
                        sys_ctrl_pkg::MAIN_FROM_INTERNAL,
                        sys_ctrl_pkg::PIN_FROM_INTERNAL};
      state.active <= {sys_ctrl_pkg::PLL_FROM_INTERNAL,
                       sys_ctrl_pkg::MAIN_FROM_INTERNAL,
                       sys_ctrl_pkg::PIN_FROM_INTERNAL};
      state.pllUpd <= 1'b0;
      state.mainUpd <= 1'b0;
      state.pinUpd <= 1'b0;
      state.gate <= sys_ctrl_pkg::GATE_RST;
      state.div <= sys_ctrl_pkg::DIV_RST;
      state.cnt <= '0;
      state.tick <= '0;
      state.pllCtrl <= 32'h0;
      state.plain <= sys_ctrl_pkg::PLAIN_RST;
      state.rstStat <= '0;
      state.capDone <= 1'b0;
      state.cap0 <= 32'h0;
      state.cap1 <= 32'h0;
    end else begin
      state <= next_state;
    end
  end

  assign apbRsp = state.rsp;
  assign vectorMap = state.map;
  assign fetchToRom = state.romHit;
  assign fetchToRam = state.ramHit;
  assign periphResetN = state.presetN;
  assign clockGate = state.gate;
  assign clockSel = state.active;
  assign dividerTick = state.tick;
  assign pllConfig = state.pllCtrl;
  assign configWords = state.plain;

endmodule // system_clock_reset_control

`default_nettype wire

// *** system_clock_reset_control_asserts.sv ***
// assertions on the ports of the system clock and reset control block
// assumes one clock domain with the asynchronous active low reset
`default_nettype none

module system_clock_reset_control_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire sys_ctrl_pkg::apb_req_s apbReq,
  input wire sys_ctrl_pkg::apb_rsp_s apbRsp,
  input wire logic [31:0] fetchAddr,
  input wire sys_ctrl_pkg::remap_e vectorMap,
  input wire logic fetchToRom,
  input wire logic fetchToRam,
  input wire logic [11:0] periphResetN,
  input wire logic [31:0] clockGate,
  input wire sys_ctrl_pkg::clk_sel_s clockSel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [31:0] lastWdata;
  logic [11:0] off;
  logic accWr, updWr, outside, low;
  always_ff @(posedge clk) lastWdata <= apbReq.pwdata;
  assign off = apbReq.paddr[11:0];
  assign outside = apbReq.paddr[31:14] != sys_ctrl_pkg::BASE_ADDR[31:14];
  assign accWr = apbReq.psel && apbReq.penable && apbReq.pwrite &&
    apbRsp.pready && apbReq.paddr[31:12] == 20'h40048;
  assign updWr = accWr && (off[11:2] == 10'h011 || off[11:2] == 10'h01d ||
    off[11:2] == 10'h039);
  assign low = fetchAddr < sys_ctrl_pkg::REMAP_WINDOW;
  sequence s_setup;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence s_answer;
    apbRsp.pready ##1 !apbRsp.pready;
  endsequence
  chk_ready_once: assert property (
    s_setup |=> s_answer) else $error("ready not one access cycle");
  chk_outside_err: assert property (
    apbReq.psel && !apbReq.penable && outside |=>
    apbRsp.pslverr && apbRsp.prdata == 32'h0)
    else $error("outside access not refused");
  chk_preset_write: assert property (
    accWr && off == 12'h004 |=>
    periphResetN == (lastWdata[11:0] & sys_ctrl_pkg::PRESET_MASK))
    else $error("soft reset word wrong");
  chk_gate_write: assert property (
    accWr && off == 12'h080 |=> clockGate == lastWdata)
    else $error("gating word wrong");
  chk_sel_held: assert property (
    !updWr |=> $stable(clockSel)) else $error("select moved alone");
  chk_pll_legal: assert property (
    clockSel.pll != sys_ctrl_pkg::PLL_RESERVED) else $error("pll code 3");
  chk_map_legal: assert property (
    vectorMap != sys_ctrl_pkg::MAP_RESERVED) else $error("map code 3");
  chk_rom_hit: assert property (
    vectorMap == sys_ctrl_pkg::MAP_BOOT_ROM && low |=>
    fetchToRom && !fetchToRam) else $error("rom hit missing");
  chk_ram_hit: assert property (
    vectorMap == sys_ctrl_pkg::MAP_RAM && low |=> fetchToRam && !fetchToRom)
    else $error("ram hit missing");
  chk_no_remap: assert property (
    !low || vectorMap == sys_ctrl_pkg::MAP_FLASH |=>
    !fetchToRom && !fetchToRam) else $error("stray remap hit");
endmodule // system_clock_reset_control_asserts

bind system_clock_reset_control system_clock_reset_control_asserts u_chk (
  .clk, .arst_n, .apbReq, .apbRsp, .fetchAddr, .vectorMap, .fetchToRom,
  .fetchToRam, .periphResetN, .clockGate, .clockSel);

`default_nettype wire

// *** system_clock_reset_control_tb.sv ***
// self-checking bench for the system clock and reset control block
// assumes the block is the only slave on its register bus
`default_nettype none

module system_clock_reset_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BA = sys_ctrl_pkg::BASE_ADDR;
  logic clk, arst_n, fetchToRom, fetchToRam, err;
  sys_ctrl_pkg::apb_req_s apbReq;
  sys_ctrl_pkg::apb_rsp_s apbRsp;
  sys_ctrl_pkg::remap_e vectorMap;
  sys_ctrl_pkg::clk_sel_s clockSel;
  logic [31:0] fetchAddr, clockGate, pllConfig, rd;
  logic [11:0] periphResetN;
  logic [sys_ctrl_pkg::NUM_DIV-1:0] dividerTick;
  logic [sys_ctrl_pkg::NUM_PLAIN-1:0][31:0] configWords;
  int error_cnt = 0;
  int tests_run = 0;

  system_clock_reset_control DUT (.clk, .arst_n, .apbReq, .apbRsp,
    .pllLocked(1'b1), .resetCauseEvent(5'h00), .porPins0(32'h00c0ffee),
    .porPins1(32'h0), .fetchAddr, .vectorMap, .fetchToRom, .fetchToRam,
    .periphResetN, .clockGate, .clockSel, .dividerTick, .pllConfig,
    .configWords);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one setup and one access phase, answer taken at the ready edge
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 8);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    chk(n, 1);
  endtask

  task automatic wr(input logic [11:0] o, input logic [31:0] d);
    apb(1'b1, BA + {20'h0, o}, d);
  endtask

  task automatic rdc(input logic [11:0] o, input logic [31:0] e);
    apb(1'b0, BA + {20'h0, o}, 32'h0);
    chk(rd, e);
  endtask

  task automatic t_reset;
    @(negedge clk);
    chk(vectorMap, sys_ctrl_pkg::MAP_FLASH);
    chk(clockSel, 7'h00);
    chk(periphResetN, 12'h000);
    chk(clockGate, sys_ctrl_pkg::GATE_RST);
    chk(pllConfig, 32'h0);
    chk(configWords[15], 32'h0000_edf0);
    rdc(12'h00c, 32'h1);
    rdc(12'h000, 32'h2);
    rdc(12'h080, 32'h1f);
    rdc(12'h100, 32'h00c0ffee);
    $display("reset test done");
  endtask

  task automatic t_remap;
    @(posedge clk) fetchAddr <= 32'h1fc;
    wr(12'h000, 32'h0);
    repeat (2) @(negedge clk);
    chk({fetchToRom, fetchToRam}, 2'b10);
    wr(12'h000, 32'h1);
    repeat (2) @(negedge clk);
    chk({fetchToRom, fetchToRam}, 2'b01);
    wr(12'h000, 32'h3);
    rdc(12'h000, 32'h1);
    @(posedge clk) fetchAddr <= 32'h200;
    repeat (2) @(negedge clk);
    chk({fetchToRom, fetchToRam}, 2'b00);
    wr(12'h000, 32'h2);
    @(negedge clk);
    chk(vectorMap, sys_ctrl_pkg::MAP_FLASH);
    $display("remap test done");
  endtask

  task automatic t_preset;
    wr(12'h004, 32'hffff_ffff);
    rdc(12'h004, 32'h0000_0ff7);
    @(negedge clk);
    chk(periphResetN, 12'hff7);
    wr(12'h004, 32'h0000_0010);
    wr(12'h080, 32'h0000_0a5f);
    wr(12'h008, 32'h0000_0065);
    wr(12'h02c, 32'h0000_0012);
    @(negedge clk);
    chk(periphResetN, 12'h010);
    chk(clockGate, 32'h0000_0a5f);
    chk(pllConfig, 32'h0000_0065);
    chk(configWords[3], 32'h0000_0012);
    $display("soft reset test done");
  endtask

  task automatic t_select;
    logic [11:0] so[3] = '{12'h040, 12'h070, 12'h0e0};
    logic [2:0] sv[3] = '{3'h1, 3'h3, 3'h4};
    logic [6:0] was[3] = '{7'h00, 7'h20, 7'h38};
    logic [6:0] now[3] = '{7'h20, 7'h38, 7'h3c};
    for (int i = 0; i < 3; i++) begin
      wr(so[i], {29'h0, sv[i]});
      @(negedge clk);
      chk(clockSel, was[i]);
      wr(so[i] + 12'h004, 32'h0);
      wr(so[i] + 12'h004, 32'h1);
      @(negedge clk);
      chk(clockSel, now[i]);
    end
    wr(12'h040, 32'h3);
    wr(12'h0e0, 32'h5);
    wr(12'h044, 32'h0);
    wr(12'h044, 32'h1);
    wr(12'h0e4, 32'h0);
    wr(12'h0e4, 32'h1);
    @(negedge clk);
    chk(clockSel, 7'h3c);
    $display("select test done");
  endtask

  task automatic t_div;
    int c[4];
    logic [7:0] pv[2] = '{8'hff, 8'h02};
    wr(12'h098, 32'h3);
    wr(12'h094, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(12'h0e8, {24'h0, pv[k]});
      repeat (260) @(posedge clk);
      c = '{0, 0, 0, 0};
      repeat (510) begin
        @(posedge clk);
        c[0] += dividerTick[0];
        c[1] += dividerTick[1];
        c[2] += dividerTick[2];
        c[3] += dividerTick[6];
      end
      chk(c[0], 510);
      chk(c[1], 0);
      chk(c[2], 170);
      chk(c[3], 510 / pv[k]);
    end
    $display("divider test done");
  endtask

  task automatic t_bad;
    rdc(12'h0a0, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, BA + 32'h4000, 32'h1);
    chk(err, 1'b1);
    apb(1'b1, BA + 32'h1000, 32'h1);
    chk(err, 1'b1);
    rdc(12'h000, 32'h2);
    apb(1'b0, BA + 32'h2, 32'h0);
    chk(err, 1'b0);
    chk(rd, 32'h2);
    $display("refusal test done");
  endtask

  initial begin
    arst_n = 1'b0;
    apbReq = '0;
    fetchAddr = 32'h0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_remap;
    t_preset;
    t_select;
    t_div;
    t_bad;
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    finish_test;
  end

  initial begin
    #100us;
    error_cnt++;
    finish_test;
  end
endmodule // system_clock_reset_control_tb

`default_nettype wire
